// File: verilog/lrc_params.svh
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH

// register byte addresses
`define LRC_CIPHER_CONTROL_ADDR   32'h4000_00c0
`define LRC_KEY_WORD0_ADDR        32'h4000_00c4
`define LRC_KEY_WORD1_ADDR        32'h4000_00c8
`define LRC_KEY_WORD2_ADDR        32'h4000_00cc
`define LRC_KEY_WORD3_ADDR        32'h4000_00d0
`define LRC_BLOCK_POINTER_ADDR    32'h4000_00d4
`define LRC_TX_CODE_ADDR          32'h4000_00d8
`define LRC_RX_CODE_ADDR          32'h4000_00dc
`define LRC_RF_TEST_ADDR          32'h4000_00e0
`define LRC_PREFETCH_ADDR         32'h4000_00f0
`define LRC_COARSE_TGT_ADDR       32'h4000_00f4
`define LRC_PRECISE_TGT_ADDR      32'h4000_00f8
`define LRC_SAMPLE_ADDR           32'h4000_00fc
`define LRC_BASE_VALUE_ADDR       32'h4000_0100
`define LRC_MISC_CONTROL_ADDR     32'h4000_0200

// rf test control fields
`define LRC_RFT_ENDLESS_RX_BIT    31
`define LRC_RFT_ENDLESS_TX_BIT    15
`define LRC_RFT_LEN_SRC_BIT       14
`define LRC_RFT_SEQ_TYPE_BIT      13
`define LRC_RFT_PLD_SRC_BIT       12
`define LRC_RFT_LEN_MSB           8

// misc control fields
`define LRC_MISC_SIG_SEL_BIT      21
`define LRC_MISC_WAKE_STAT_BIT    20
`define LRC_MISC_SERIAL_BIT       19
`define LRC_MISC_BASEBAND_BIT     18
`define LRC_MISC_RADIO_BIT        17

// field widths
`define LRC_POINTER_W             16
`define LRC_PREFETCH_W            8
`define LRC_COARSE_W              16
`define LRC_BASE_W                27
`define LRC_LEN_W                 9

// reset values and sequence seeds
`define LRC_RESET_WORD            32'h0000_0000
`define LRC_SEED_SHORT            15'h01ff
`define LRC_SEED_LONG             15'h7fff

// base counter unit
`define LRC_BASE_UNIT_NS          625000
`define LRC_CLK_PERIOD_NS         8

`endif

// File: verilog/lrc_pkg.sv
`include "lrc_params.svh"

package lrc_pkg;

   // low-power wake acknowledge sequence
   typedef enum logic [1:0] {
      LRC_WAKE_IDLE,
      LRC_WAKE_ACTIVE,
      LRC_WAKE_POWERED,
      LRC_WAKE_PERIOD
   } lrc_wake_e;

   typedef struct packed {
      logic [31:0]                 key0;
      logic [31:0]                 key1;
      logic [31:0]                 key2;
      logic [31:0]                 key3;
      logic                        cipher_busy;
      logic                        cipher_start;
      logic [`LRC_POINTER_W-1:0]   pointer;
      logic [31:0]                 tx_code;
      logic [31:0]                 rx_code;
      logic                        endless_rx;
      logic                        endless_tx;
      logic                        len_src;
      logic                        seq_type;
      logic                        pld_src;
      logic [`LRC_LEN_W-1:0]       test_len;
      logic [`LRC_PREFETCH_W-1:0]  prefetch;
      logic [`LRC_COARSE_W-1:0]    coarse_tgt;
      logic [`LRC_BASE_W-1:0]      precise_tgt;
      logic                        sample_pend;
      logic [`LRC_BASE_W-1:0]      base_cnt;
      logic [`LRC_BASE_W-1:0]      base_value;
      logic [16:0]                 tick_div;
      logic                        coarse_irq;
      logic                        precise_irq;
      logic                        sig_sel;
      logic                        serial_bit;
      logic                        baseband_bit;
      logic                        radio_bit;
      lrc_wake_e                   wake;
      logic                        wake_stat;
      logic [7:0]                  sig_strength;
      logic [`LRC_LEN_W-1:0]       pld_len;
      logic [14:0]                 lfsr;
      logic                        pld_bit;
      logic [31:0]                 rdata;
   } lrc_state_s;

endpackage

// File: verilog/lrc_regs.sv
// How it works
// [RULE1] key bits 127..64 held in two read/write words, reset zero
// [RULE2] sixteen-bit block pointer in low half of its word
// [RULE3] integrity codes read-only, captured at cipher done even when masked
// [RULE4] endless receive bit 31 keeps receive window open
// [RULE5] endless transmit bit 15 gives endless payload, repeating test length
// [RULE6] bit 14 picks payload length: descriptor or test length
// [RULE7] bit 13 picks nine-stage or fifteen-stage sequence
// [RULE8] shift registers seeded all ones before payload generation
// [RULE9] bit 12 picks payload from memory or sequence generator
// [RULE10] nine-bit test transmit length in low bits
// [RULE11] eight-bit table prefetch time in microseconds
// [RULE12] coarse event when target equals counter 19..4 and low nibble zero
// [RULE13] precise event when target equals whole base counter
// [RULE14] writing one to sample bit copies counter, bit then self-clears
// [RULE15] bit 21 selects peak-hold or average signal strength
// [RULE16] software waits for wake status bit 20 to clear
// [RULE17] wake status cleared after radio power-up plus one low-power period
// [RULE18] software keeps control bits 19, 18, 17 at zero
// [RULE19] cipher start bit begins run, clears itself at cipher done
// [RULE20] key bits 63..0 held in two more read/write words
// [RULE21] each target match gives one pulse per counter update
// [RULE22] reserved bits read zero, writes to them ignored
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lrc_params.svh"

module lrc_regs #(
   parameter int TICK_CYC = `LRC_BASE_UNIT_NS / `LRC_CLK_PERIOD_NS
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [31:0]  addr,
   input  wire logic [31:0]  wdata,
   input  wire logic         wr,
   input  wire logic         rd,
   output logic      [31:0]  rdata,
   input  wire logic         cipher_done_interrupt,
   input  wire logic [31:0]  cipher_tx_code_in,
   input  wire logic [31:0]  cipher_rx_code_in,
   output logic              cipher_start,
   output logic              cipher_busy,
   output logic      [127:0] cipher_key,
   output logic      [15:0]  cipher_block_pointer,
   output logic              endless_receive_window,
   output logic              endless_transmit_payload,
   output logic      [8:0]   test_transmit_length,
   input  wire logic [8:0]   descriptor_adv_length,
   output logic      [8:0]   payload_length,
   input  wire logic         sequence_restart,
   input  wire logic         sequence_advance,
   input  wire logic         memory_payload_bit,
   output logic              payload_bit,
   output logic      [7:0]   table_prefetch_time,
   output logic              coarse_target_interrupt,
   output logic              precise_target_interrupt,
   input  wire logic [7:0]   peak_strength,
   input  wire logic [7:0]   average_strength,
   output logic      [7:0]   signal_strength,
   input  wire logic         lowpower_wake_event,
   input  wire logic         radio_powered,
   input  wire logic         lowpower_clk_tick,
   output logic              lowpower_wake_interrupt,
   output logic              serial_replace_bit,
   output logic              baseband_alone_bit,
   output logic              radio_alone_bit
);

   lrc_pkg::lrc_state_s s_r;
   lrc_pkg::lrc_state_s s_nxt;

   localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);

   // one decode shared by write and read sides
   function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   // sequence feedback for either length
   function automatic logic seq_fb(input logic [14:0] v, input logic long_sel);
      if (long_sel)
         seq_fb = v[13] ^ v[12] ^ v[11] ^ v[1] ^ v[0];
      else
         seq_fb = v[8] ^ v[4];
   endfunction

   // next-state logic for the whole bank
   always_comb
   begin
      logic [`LRC_BASE_W-1:0] cnt_new;
      logic                   tick;
      cnt_new = s_r.base_cnt;
      tick    = 1'b0;
      s_nxt   = s_r;

      // base counter runs on a divided enable; one clock only
      if (s_r.tick_div == TICK_LAST)
      begin
         s_nxt.tick_div = 17'h0_0000;
         tick           = 1'b1;
         cnt_new        = s_r.base_cnt + 27'h000_0001;
      end
      else
      begin
         s_nxt.tick_div = s_r.tick_div + 17'h0_0001;
      end
      s_nxt.base_cnt = cnt_new;

      // matches judged only on an update so each gives a single pulse
      s_nxt.coarse_irq = tick && (cnt_new[19:4] == s_r.coarse_tgt)                  // [RULE12] [RULE21]
                         && (cnt_new[3:0] == 4'h0);
      s_nxt.precise_irq = tick && (cnt_new == s_r.precise_tgt);                     // [RULE13] [RULE21]

      // sample copy takes the cycle after the write, then the bit drops
      if (s_r.sample_pend)
      begin
         s_nxt.base_value  = s_r.base_cnt;                                          // [RULE14]
         s_nxt.sample_pend = 1'b0;                                                  // [RULE14]
      end

      // cipher run: start pulses once, busy bit clears at done
      s_nxt.cipher_start = 1'b0;
      if (cipher_done_interrupt)
      begin
         s_nxt.cipher_busy = 1'b0;                                                  // [RULE19]
         s_nxt.tx_code     = cipher_tx_code_in;                                     // [RULE3]
         s_nxt.rx_code     = cipher_rx_code_in;                                     // [RULE3]
      end

      // wake status: event sets, power-up then a full low-power period clears
      unique case (s_r.wake)
         lrc_pkg::LRC_WAKE_IDLE:    ;
         lrc_pkg::LRC_WAKE_ACTIVE:
            if (radio_powered)
               s_nxt.wake = lrc_pkg::LRC_WAKE_POWERED;
         lrc_pkg::LRC_WAKE_POWERED:
            if (lowpower_clk_tick)
               s_nxt.wake = lrc_pkg::LRC_WAKE_PERIOD;
         lrc_pkg::LRC_WAKE_PERIOD:
            if (lowpower_clk_tick)
               s_nxt.wake = lrc_pkg::LRC_WAKE_IDLE;                                 // [RULE17]
      endcase
      // a new event beats the self-acknowledge
      if (lowpower_wake_event)
         s_nxt.wake = lrc_pkg::LRC_WAKE_ACTIVE;
      // status kept in its own flop so the pin needs no decode
      s_nxt.wake_stat = (s_nxt.wake != lrc_pkg::LRC_WAKE_IDLE);                    // [RULE17]

      // register writes; only defined bits are stored
      if (wr)
      begin
         if (hit(addr, `LRC_CIPHER_CONTROL_ADDR) && wdata[0])
         begin
            s_nxt.cipher_busy  = 1'b1;                                              // [RULE19]
            s_nxt.cipher_start = 1'b1;                                              // [RULE19]
         end
         if (hit(addr, `LRC_KEY_WORD0_ADDR))
            s_nxt.key0 = wdata;                                                     // [RULE20]
         if (hit(addr, `LRC_KEY_WORD1_ADDR))
            s_nxt.key1 = wdata;                                                     // [RULE20]
         if (hit(addr, `LRC_KEY_WORD2_ADDR))
            s_nxt.key2 = wdata;                                                     // [RULE1]
         if (hit(addr, `LRC_KEY_WORD3_ADDR))
            s_nxt.key3 = wdata;                                                     // [RULE1]
         if (hit(addr, `LRC_BLOCK_POINTER_ADDR))
            s_nxt.pointer = wdata[`LRC_POINTER_W-1:0];                              // [RULE2] [RULE22]
         if (hit(addr, `LRC_RF_TEST_ADDR))
         begin
            s_nxt.endless_rx = wdata[`LRC_RFT_ENDLESS_RX_BIT];                      // [RULE4]
            s_nxt.endless_tx = wdata[`LRC_RFT_ENDLESS_TX_BIT];                      // [RULE5]
            s_nxt.len_src    = wdata[`LRC_RFT_LEN_SRC_BIT];                         // [RULE6]
            s_nxt.seq_type   = wdata[`LRC_RFT_SEQ_TYPE_BIT];                        // [RULE7]
            s_nxt.pld_src    = wdata[`LRC_RFT_PLD_SRC_BIT];                         // [RULE9]
            s_nxt.test_len   = wdata[`LRC_RFT_LEN_MSB:0];                           // [RULE10]
         end
         if (hit(addr, `LRC_PREFETCH_ADDR))
            s_nxt.prefetch = wdata[`LRC_PREFETCH_W-1:0];                            // [RULE11]
         if (hit(addr, `LRC_COARSE_TGT_ADDR))
            s_nxt.coarse_tgt = wdata[`LRC_COARSE_W-1:0];                            // [RULE12]
         if (hit(addr, `LRC_PRECISE_TGT_ADDR))
            s_nxt.precise_tgt = wdata[`LRC_BASE_W-1:0];                             // [RULE13]
         if (hit(addr, `LRC_SAMPLE_ADDR) && wdata[0])
            s_nxt.sample_pend = 1'b1;                                               // [RULE14]
         if (hit(addr, `LRC_MISC_CONTROL_ADDR))
         begin
            s_nxt.sig_sel      = wdata[`LRC_MISC_SIG_SEL_BIT];                      // [RULE15]
            s_nxt.serial_bit   = wdata[`LRC_MISC_SERIAL_BIT];                       // [RULE18]
            s_nxt.baseband_bit = wdata[`LRC_MISC_BASEBAND_BIT];                     // [RULE18]
            s_nxt.radio_bit    = wdata[`LRC_MISC_RADIO_BIT];                        // [RULE18]
         end
      end

      // payload length and source muxes, registered toward the radio
      s_nxt.pld_len      = s_r.len_src ? s_r.test_len : descriptor_adv_length;     // [RULE6]
      s_nxt.sig_strength = s_r.sig_sel ? average_strength : peak_strength;         // [RULE15]

      // sequence generator; reseeded on restart or on any write to the rf test word
      if (sequence_restart || (wr && hit(addr, `LRC_RF_TEST_ADDR)))
         s_nxt.lfsr = s_nxt.seq_type ? `LRC_SEED_LONG : `LRC_SEED_SHORT;           // [RULE8]
      else if (sequence_advance)
      begin
         if (s_r.seq_type)
            s_nxt.lfsr = {s_r.lfsr[13:0], seq_fb(s_r.lfsr, 1'b1)};                 // [RULE7]
         else
            s_nxt.lfsr = {6'h00, s_r.lfsr[7:0], seq_fb(s_r.lfsr, 1'b0)};           // [RULE7]
      end
      s_nxt.pld_bit = s_r.pld_src ? (s_r.seq_type ? s_r.lfsr[14] : s_r.lfsr[8])   // [RULE9]
                                  : memory_payload_bit;

      // read data stands only in the cycle after the strobe
      s_nxt.rdata = `LRC_RESET_WORD;
      if (rd)
      begin
         unique case (1'b1)
            hit(addr, `LRC_CIPHER_CONTROL_ADDR): s_nxt.rdata = {31'h0000_0000, s_r.cipher_busy};
            hit(addr, `LRC_KEY_WORD0_ADDR):      s_nxt.rdata = s_r.key0;
            hit(addr, `LRC_KEY_WORD1_ADDR):      s_nxt.rdata = s_r.key1;
            hit(addr, `LRC_KEY_WORD2_ADDR):      s_nxt.rdata = s_r.key2;
            hit(addr, `LRC_KEY_WORD3_ADDR):      s_nxt.rdata = s_r.key3;
            hit(addr, `LRC_BLOCK_POINTER_ADDR):  s_nxt.rdata = {16'h0000, s_r.pointer};     // [RULE22]
            hit(addr, `LRC_TX_CODE_ADDR):        s_nxt.rdata = s_r.tx_code;                  // [RULE3]
            hit(addr, `LRC_RX_CODE_ADDR):        s_nxt.rdata = s_r.rx_code;                  // [RULE3]
            hit(addr, `LRC_RF_TEST_ADDR):
               s_nxt.rdata = {s_r.endless_rx, 15'h0000, s_r.endless_tx, s_r.len_src,
                              s_r.seq_type, s_r.pld_src, 3'h0, s_r.test_len};               // [RULE22]
            hit(addr, `LRC_PREFETCH_ADDR):       s_nxt.rdata = {24'h00_0000, s_r.prefetch};
            hit(addr, `LRC_COARSE_TGT_ADDR):     s_nxt.rdata = {16'h0000, s_r.coarse_tgt};
            hit(addr, `LRC_PRECISE_TGT_ADDR):    s_nxt.rdata = {5'h00, s_r.precise_tgt};
            hit(addr, `LRC_SAMPLE_ADDR):         s_nxt.rdata = {31'h0000_0000, s_r.sample_pend};
            hit(addr, `LRC_BASE_VALUE_ADDR):     s_nxt.rdata = {5'h00, s_r.base_value};
            hit(addr, `LRC_MISC_CONTROL_ADDR):
               s_nxt.rdata = {10'h000, s_r.sig_sel, s_r.wake_stat,
                              s_r.serial_bit, s_r.baseband_bit, s_r.radio_bit, 17'h0_0000};
            default:                             s_nxt.rdata = `LRC_RESET_WORD;
         endcase
      end
   end

   // whole bank in one register; reset to constants only
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_r      <= '0;
         s_r.wake <= lrc_pkg::LRC_WAKE_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state flops
   assign rdata                    = s_r.rdata;
   assign cipher_start             = s_r.cipher_start;
   assign cipher_busy              = s_r.cipher_busy;
   assign cipher_key               = {s_r.key3, s_r.key2, s_r.key1, s_r.key0};
   assign cipher_block_pointer     = s_r.pointer;
   assign endless_receive_window   = s_r.endless_rx;
   assign endless_transmit_payload = s_r.endless_tx;
   assign test_transmit_length     = s_r.test_len;
   assign payload_length           = s_r.pld_len;
   assign payload_bit              = s_r.pld_bit;
   assign table_prefetch_time      = s_r.prefetch;
   assign coarse_target_interrupt  = s_r.coarse_irq;
   assign precise_target_interrupt = s_r.precise_irq;
   assign signal_strength          = s_r.sig_strength;
   assign lowpower_wake_interrupt  = s_r.wake_stat;
   assign serial_replace_bit       = s_r.serial_bit;
   assign baseband_alone_bit       = s_r.baseband_bit;
   assign radio_alone_bit          = s_r.radio_bit;

   // checks on the bank's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence key_write_s;
      wr && (addr == `LRC_KEY_WORD3_ADDR);
   endsequence

   sequence cipher_run_s;
      wr && (addr == `LRC_CIPHER_CONTROL_ADDR) && wdata[0] && !cipher_done_interrupt;
   endsequence

   key_word_a: assert property (key_write_s |=> cipher_key[127:96] == $past(wdata))  // [RULE1]
      else $error("upper key word not stored");
   pointer_low_a: assert property (rd && addr == `LRC_BLOCK_POINTER_ADDR |=> rdata[31:16] == 16'h0000) // [RULE2]
      else $error("pointer upper half not zero");
   code_capture_a: assert property (cipher_done_interrupt |=> s_r.tx_code == $past(cipher_tx_code_in) // [RULE3]
                                    && s_r.rx_code == $past(cipher_rx_code_in))
      else $error("integrity codes not captured at done");
   start_clear_a: assert property (cipher_run_s |=> cipher_busy && cipher_start ##1 // [RULE19]
                                   (!cipher_start || $past(wr)) && (cipher_busy || $past(cipher_done_interrupt)))
      else $error("cipher start sequencing wrong");
   busy_clear_a: assert property (cipher_done_interrupt && !(wr && addr == `LRC_CIPHER_CONTROL_ADDR) // [RULE19]
                                  |=> !cipher_busy)
      else $error("cipher busy not cleared at done");
   wake_set_a: assert property (lowpower_wake_event |=> lowpower_wake_interrupt) // [RULE17]
      else $error("wake status not set by event");
   coarse_pulse_a: assert property (coarse_target_interrupt |=> !coarse_target_interrupt) // [RULE21]
      else $error("coarse event longer than one cycle");
   coarse_match_a: assert property (coarse_target_interrupt |-> s_r.base_cnt[3:0] == 4'h0 // [RULE12]
                                    && s_r.base_cnt[19:4] == $past(s_r.coarse_tgt))
      else $error("coarse event without match");
   precise_match_a: assert property (precise_target_interrupt |-> s_r.base_cnt == $past(s_r.precise_tgt)) // [RULE13]
      else $error("precise event without match");
   sample_clear_a: assert property (wr && addr == `LRC_SAMPLE_ADDR && wdata[0] // [RULE14]
                                    |=> s_r.sample_pend ##1 !s_r.sample_pend && s_r.base_value == $past(s_r.base_cnt))
      else $error("sample bit did not copy and clear");
   strength_sel_a: assert property (s_r.sig_sel && $stable(s_r.sig_sel) |=> signal_strength == $past(average_strength)) // [RULE15]
      else $error("average strength not selected");
   wake_ack_a: assert property (s_r.wake == lrc_pkg::LRC_WAKE_PERIOD && lowpower_clk_tick // [RULE17]
                                && !lowpower_wake_event |=> !lowpower_wake_interrupt)
      else $error("wake status not acknowledged");
   seed_a: assert property (sequence_restart && !wr |=> s_r.lfsr == (s_r.seq_type ? `LRC_SEED_LONG : `LRC_SEED_SHORT)) // [RULE8]
      else $error("sequence not seeded with ones");
   length_src_a: assert property (s_r.len_src |=> payload_length == $past(s_r.test_len)) // [RULE6]
      else $error("test length not used");

endmodule

`default_nettype wire

// File: bench/lowenergy_radio_core_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lowenergy_radio_core_regs_bench;
   // bench-driven inputs, all given a value at time zero
   logic          clk = 0;
   logic          arst_n = 0;
   logic [31:0]   addr = 0, wdata = 0, tx_code = 0, rx_code = 0, q, v;
   logic          wr = 0, rd = 0, done = 0, restart = 0, mem_bit = 0, adv = 0;
   logic [8:0]    m;
   logic          wake_ev = 0, powered = 0, lp_tick = 0;
   logic [8:0]    adv_len = 9'h1a3;
   logic [7:0]    peak = 8'h5a, avg = 8'ha5;
   // design outputs
   logic [31:0]   rdata;
   logic [127:0]  key;
   logic [15:0]   ptr;
   logic [8:0]    tlen, plen;
   logic [7:0]    pref, sig;
   logic          start, busy, erx, etx, pbit, c_irq, p_irq, w_irq, ser, bb, rad;
   int            errors = 0, n_compared = 0, np = 0, nc = 0;
   logic [31:0]   seed = 32'h0000_e6dc;
   logic [31:0]   mdl [int unsigned];
   // mapped words, two read-only codes and one unmapped hole; mask is what reads back
   localparam logic [31:0] ADR [13] = '{32'h4000_00c4, 32'h4000_00c8, 32'h4000_00cc, 32'h4000_00d0,
      32'h4000_00d4, 32'h4000_00e0, 32'h4000_00f0, 32'h4000_00f4, 32'h4000_00f8, 32'h4000_0200,
      32'h4000_00d8, 32'h4000_00dc, 32'h4000_00e4};
   localparam logic [31:0] MSK [13] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
      32'h0000_ffff, 32'h8000_f1ff, 32'h0000_00ff, 32'h0000_ffff, 32'h07ff_ffff, 32'h002e_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

   // short tick so the base counter moves every four cycles
   lrc_regs #(.TICK_CYC(4)) dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cipher_done_interrupt(done), .cipher_tx_code_in(tx_code), .cipher_rx_code_in(rx_code),
      .cipher_start(start), .cipher_busy(busy), .cipher_key(key), .cipher_block_pointer(ptr),
      .endless_receive_window(erx), .endless_transmit_payload(etx), .test_transmit_length(tlen),
      .descriptor_adv_length(adv_len), .payload_length(plen), .sequence_restart(restart),
      .sequence_advance(adv), .memory_payload_bit(mem_bit), .payload_bit(pbit), .table_prefetch_time(pref),
      .coarse_target_interrupt(c_irq), .precise_target_interrupt(p_irq), .peak_strength(peak),
      .average_strength(avg), .signal_strength(sig), .lowpower_wake_event(wake_ev), .radio_powered(powered),
      .lowpower_clk_tick(lp_tick), .lowpower_wake_interrupt(w_irq), .serial_replace_bit(ser),
      .baseband_alone_bit(bb), .radio_alone_bit(rad));

   always #4 clk = ~clk;

   // event pulses are counted so a held level shows up as extra pulses
   always @(posedge clk)
   begin
      if (p_irq === 1'b1) np++;
      if (c_irq === 1'b1) nc++;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
         errors++;
      end
   endtask

   // one-cycle strobes with a free cycle between, so no strobe is assigned twice per step
   task automatic wr_t(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_t(input logic [31:0] a, output logic [31:0] r);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 r = rdata;
   endtask

   task automatic rdchk(input logic [31:0] a);
      logic [31:0] r;
      rd_t(a, r);
      chk(r, mdl[a], "register readback");
   endtask

   task automatic results();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // the whole run is a few hundred cycles; this is far beyond it
   initial
   begin
      #(8 * 20000);
      errors++;
      results();
   end

   initial
   begin
      foreach (ADR[i]) mdl[ADR[i]] = 32'h0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      foreach (ADR[i]) rdchk(ADR[i]);
      // random words; control bits 19..17 stay clear as software must keep them
      foreach (ADR[i])
      begin
         v = xs() & 32'hfff1_ffff;
         wr_t(ADR[i], v);
         mdl[ADR[i]] = v & MSK[i];
      end
      foreach (ADR[i]) rdchk(ADR[i]);
      @(posedge clk);
      #1 chk(key, {mdl[32'h4000_00d0], mdl[32'h4000_00cc], mdl[32'h4000_00c8], mdl[32'h4000_00c4]}, "key");
      chk(ptr, mdl[32'h4000_00d4][15:0], "pointer");
      chk(pref, mdl[32'h4000_00f0][7:0], "prefetch");
      v = mdl[32'h4000_00e0];
      chk({erx, etx, tlen}, {v[31], v[15], v[8:0]}, "test flags");
      chk(plen, v[14] ? v[8:0] : adv_len, "payload length");
      chk(sig, mdl[32'h4000_0200][21] ? avg : peak, "strength select");
      chk({ser, bb, rad}, 3'b000, "reserved control bits");
      // every sequence type and payload source; memory bit differs between the two memory cases
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk);
         mem_bit <= k[1];
         wr_t(32'h4000_00e0, k << 12);
         repeat (2) @(posedge clk);
         #1 chk(pbit, k[0] ? 1'b1 : mem_bit, "payload bit");
         chk(plen, adv_len, "descriptor length");
      end
      // short sequence stepped from its seed, restarted part way through
      wr_t(32'h4000_00e0, 32'h0000_1000);
      mdl[32'h4000_00e0] = 32'h0000_1000;
      adv <= 1'b1;
      m = 9'h1ff;
      for (int k = 0; k < 40; k++)
      begin
         @(posedge clk);
         restart <= (k == 19);
         adv <= (k < 39);
         #1 chk(pbit, m[8], "sequence bit");
         m = (k == 20) ? 9'h1ff : {m[7:0], m[8] ^ m[4]};
      end
      // cipher run: start sets busy, done clears it and latches both codes
      wr_t(32'h4000_00c0, 32'h0000_0001);
      #1 chk({busy, start}, 2'b11, "cipher start");
      @(posedge clk);
      #1 chk({busy, start}, 2'b10, "cipher busy");
      @(posedge clk);
      tx_code <= xs();
      rx_code <= xs();
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      mdl[32'h4000_00d8] = tx_code;
      mdl[32'h4000_00dc] = rx_code;
      @(posedge clk);
      #1 chk(busy, 1'b0, "cipher idle");
      rdchk(32'h4000_00d8);
      rdchk(32'h4000_00dc);
      // counter sample, then timer targets just ahead of the sampled count
      wr_t(32'h4000_00fc, 32'h0000_0001);
      rd_t(32'h4000_00fc, q);
      chk(q, 32'h0, "sample self clear");
      rd_t(32'h4000_0100, v);
      chk({v[31:27], |v}, 6'b00_0001, "sampled count");
      wr_t(32'h4000_00f8, v + 20);
      wr_t(32'h4000_00f4, {16'h0, v[19:4] + 16'h0002});
      np = 0;
      nc = 0;
      repeat (300) @(posedge clk);
      chk(np, 1, "precise pulses");
      chk(nc, 1, "coarse pulses");
      // wake status set by event, cleared after power-up and a low-power period
      @(posedge clk);
      wake_ev <= 1'b1;
      @(posedge clk);
      wake_ev <= 1'b0;
      powered <= 1'b1;
      rd_t(32'h4000_0200, q);
      chk({w_irq, q[20]}, 2'b11, "wake status set");
      for (int k = 0; k < 2; k++)
      begin
         repeat (4) @(posedge clk);
         lp_tick <= 1'b1;
         @(posedge clk);
         lp_tick <= 1'b0;
         repeat (2) @(posedge clk);
         #1 chk(w_irq, k == 0, "wake status");
      end
      rdchk(32'h4000_0200);
      results();
   end
endmodule
`default_nettype wire
